// ---- src/pwm_pkg.sv ----
package pwm_pkg;

  // ************************************************************
  // Clock
  // ************************************************************
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned CYC_PER_US     = CLK_HZ / 1_000_000;

  // ************************************************************
  // Soft start
  // ************************************************************
  localparam int unsigned SS_STEP_US     = 300;
  localparam int unsigned SS_STEP_CYC    = SS_STEP_US * CYC_PER_US;
  localparam int unsigned SS_TIME_MS     = 10;
  localparam int unsigned SS_TIME_CYC    = SS_TIME_MS * 1000 * CYC_PER_US;
  localparam int unsigned SS_STEPS       = 32;
  localparam int unsigned SS_STEP_W      = 6;
  localparam int unsigned SS_STEP_RST    = 0;

  // ************************************************************
  // Oscillator, jitter and duty limit
  // ************************************************************
  localparam int unsigned OSC_KHZ        = 100;
  localparam int unsigned OSC_PER_CYC    = CLK_HZ / (OSC_KHZ * 1000);
  localparam int unsigned OSC_W          = 12;
  localparam int unsigned JIT_PCT        = 4;
  localparam int unsigned JIT_DEV_CYC    = OSC_PER_CYC * JIT_PCT / 100;
  localparam int unsigned JIT_PERIOD_MS  = 4;
  localparam int unsigned JIT_PERIOD_CYC = JIT_PERIOD_MS * 1000 * CYC_PER_US;
  localparam int unsigned JIT_STEP_CYC   = JIT_PERIOD_CYC / (4 * JIT_DEV_CYC);
  localparam int unsigned DUTY_NUM       = 3;
  localparam int unsigned DUTY_DEN       = 4;

  // ************************************************************
  // Edge blanking (least times, rounded up)
  // ************************************************************
  localparam int unsigned EDGE_NORM_NS   = 220;
  localparam int unsigned EDGE_BURST_NS  = 180;
  localparam int unsigned EDGE_NORM_CYC  = (EDGE_NORM_NS * CYC_PER_US + 999) / 1000;
  localparam int unsigned EDGE_BURST_CYC = (EDGE_BURST_NS * CYC_PER_US + 999) / 1000;

  // ************************************************************
  // Protection blanking
  // ************************************************************
  localparam int unsigned BLANK_MS       = 20;
  localparam int unsigned BLANK_CYC      = BLANK_MS * 1000 * CYC_PER_US;
  localparam int unsigned SPIKE_MS       = 30;
  localparam int unsigned SPIKE_CYC      = SPIKE_MS * 1000 * CYC_PER_US;
  localparam int unsigned EXT_COUNT      = 256;
  localparam int unsigned TMR_W          = 24;

  typedef enum logic [2:0] {
    PROT_IDLE  = 3'h0,
    PROT_BLANK = 3'h1,
    PROT_CHG   = 3'h5,
    PROT_DIS   = 3'h4,
    PROT_SPIKE = 3'h3,
    PROT_ARST  = 3'h7
  } prot_state_t;

endpackage

// ---- src/input_sync.sv ----
`timescale 1ns/10ps

// ************************************************************
// Two-stage synchroniser for asynchronous comparator levels
// ************************************************************
module input_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t s_reg;
  sync_state_t s_next;

  always_comb
  begin
    s_next        = s_reg;
    s_next.meta   = async_in;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign sync_out = s_reg.stable;

endmodule // input_sync

// ---- src/pwm_softstart_blanking_control.sv ----
// What this block does
// - Soft start begins from step zero once supply passes the turn-on threshold.
// - Soft-start duty limit rises in 32 steps from zero to maximum duty.
// - Soft-start counter advances one step every 300 us.
// - Soft start ends 10 ms after switch-on; its duty limit then vanishes.
// - Every auto-restart attempt reruns the whole soft-start sequence.
// - Oscillator at 100 kHz, swept by plus or minus 4 percent every 4 ms.
// - Gate on-time never exceeds 0.75 of the switching period.
// - Jitter only after soft start ends; fixed frequency during soft start.
// - Oscillator sets pulse latch; feedback, soft-start or peak limit clears it.
// - Gate is off whenever the pulse latch is cleared.
// - Gate held low while supply is below the turn-off threshold.
// - Current above peak threshold clears the latch and ends the pulse.
// - Current comparisons ignored 220 ns after turn-on, 180 ns in burst.
// - In burst mode the burst comparator sets the reduced current limit.
// - Dynamic slope-compensated threshold applies to normal and burst limiting.
// - Burst and auto-restart entry need the condition held through 20 ms.
// - Only overload auto-restart blanking extends past 20 ms via capacitor.
// - Extended mode cycles blanking pin between 4.5 V and 0.9 V, counting.
// - After 256 counts and still faulted, 30 ms spike blanking, then restart.
// - Supply below turn-off stops operation and resets the soft-start counter.
`timescale 1ns/10ps

module pwm_softstart_blanking_control #(
  parameter logic [15:0] SS_STEP_CYCLES = 16'(pwm_pkg::SS_STEP_CYC),
  parameter logic [23:0] SS_TIME_CYCLES = 24'(pwm_pkg::SS_TIME_CYC),
  parameter logic [23:0] BLANK_CYCLES   = 24'(pwm_pkg::BLANK_CYC),
  parameter logic [23:0] SPIKE_CYCLES   = 24'(pwm_pkg::SPIKE_CYC)
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       vcc_on_cmp,
  input  wire logic       vcc_above_off_cmp,
  input  wire logic       feedback_cmp,
  input  wire logic       peak_limit_comparator,
  input  wire logic       burst_limit_comparator,
  input  wire logic       blank_pin_high_comparator,
  input  wire logic       blank_pin_low_comparator,
  input  wire logic       overload_fault,
  input  wire logic       burst_entry_cond,
  input  wire logic       burst_exit_cond,
  input  wire logic       extend_mode_sel,
  output logic            gate_drive,
  output logic            blank_charge_switch,
  output logic            blank_discharge_switch,
  output logic            burst_limit_gate,
  output logic [5:0]      softstart_limit_level,
  output logic            softstart_active,
  output logic            auto_restart,
  output logic            bias_on
);
  import pwm_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic                 run;
    logic [SS_STEP_W-1:0] ss_step;
    logic [15:0]          ss_tmr;
    logic [TMR_W-1:0]     ss_total;
    logic                 ss_done;
    logic [OSC_W-1:0]     osc_cnt;
    logic [OSC_W-1:0]     per_len;
    logic [7:0]           jit_pos;
    logic                 jit_up;
    logic [OSC_W-1:0]     jit_tmr;
    logic                 latch;
    logic [5:0]           edge_cnt;
    prot_state_t          prot;
    logic [TMR_W-1:0]     prot_tmr;
    logic [8:0]           ext_cnt;
    logic                 burst;
    logic [TMR_W-1:0]     burst_tmr;
  } state_t;

  localparam state_t STATE_RST = '{
    ss_step: SS_STEP_W'(SS_STEP_RST),
    per_len: OSC_W'(OSC_PER_CYC),
    jit_pos: 8'(JIT_DEV_CYC),
    jit_up:  1'b1,
    prot:    PROT_IDLE,
    default: '0
  };

  state_t s_reg;
  state_t s_next;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [10:0] sync_bus;
  logic        vcc_on_s;
  logic        vcc_ok_s;
  logic        fb_s;
  logic        peak_s;
  logic        burst_cmp_s;
  logic        bb_high_s;
  logic        bb_low_s;
  logic        fault_s;
  logic        burst_in_s;
  logic        burst_out_s;
  logic        extend_s;

  input_sync #(
    .WIDTH (11)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({vcc_on_cmp, vcc_above_off_cmp, feedback_cmp, peak_limit_comparator,
                burst_limit_comparator, blank_pin_high_comparator,
                blank_pin_low_comparator, overload_fault, burst_entry_cond,
                burst_exit_cond, extend_mode_sel}),
    .sync_out (sync_bus)
  );

  assign {vcc_on_s, vcc_ok_s, fb_s, peak_s, burst_cmp_s, bb_high_s, bb_low_s,
          fault_s, burst_in_s, burst_out_s, extend_s} = sync_bus;

  // ************************************************************
  // On-time limits
  // ************************************************************
  logic [OSC_W-1:0] duty_lim;
  logic [OSC_W-1:0] ss_lim;
  logic             cs_ok;
  logic             terminate;
  logic             sw_en;

  assign duty_lim = OSC_W'((14'(s_reg.per_len) * 14'(DUTY_NUM)) / 14'(DUTY_DEN));
  assign ss_lim   = s_reg.ss_done ? duty_lim
                  : OSC_W'((18'(duty_lim) * 18'(s_reg.ss_step)) / 18'(SS_STEPS));
  // Slope compensation lives in the analog thresholds; both limits reach the latch here
  assign cs_ok     = (s_reg.edge_cnt == 6'h00);
  assign terminate = (cs_ok && (fb_s || peak_s || (s_reg.burst && burst_cmp_s)))
                   || (s_reg.osc_cnt >= ss_lim);
  assign sw_en     = s_reg.run && (s_reg.prot != PROT_ARST);

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    s_next = s_reg;
    if (!s_reg.run)
    begin
      // Everything restarts from scratch, so each start sees a fresh soft start
      s_next = STATE_RST;
      if (vcc_on_s)
        s_next.run = 1'b1;
    end
    else if (!vcc_ok_s)
      s_next = STATE_RST;
    else
    begin
      // Soft start sequencer
      if (!s_reg.ss_done && sw_en)
      begin
        if (s_reg.ss_total == SS_TIME_CYCLES - 24'h000001)
          s_next.ss_done = 1'b1;
        else
          s_next.ss_total = s_reg.ss_total + 24'h000001;
        if (s_reg.ss_step != SS_STEP_W'(SS_STEPS))
        begin
          if (s_reg.ss_tmr == SS_STEP_CYCLES - 16'h0001)
          begin
            s_next.ss_tmr  = 16'h0000;
            s_next.ss_step = s_reg.ss_step + 6'h01;
          end
          else
            s_next.ss_tmr = s_reg.ss_tmr + 16'h0001;
        end
      end

      // Oscillator with jittered period
      if (s_reg.osc_cnt == s_reg.per_len - 12'h001)
      begin
        s_next.osc_cnt = 12'h000;
        s_next.per_len = s_reg.ss_done
                       ? OSC_W'(OSC_PER_CYC - JIT_DEV_CYC) + OSC_W'(s_reg.jit_pos)
                       : OSC_W'(OSC_PER_CYC);
      end
      else
        s_next.osc_cnt = s_reg.osc_cnt + 12'h001;

      // Triangle sweep of the period offset
      if (s_reg.ss_done)
      begin
        if (s_reg.jit_tmr == OSC_W'(JIT_STEP_CYC - 1))
        begin
          s_next.jit_tmr = 12'h000;
          if (s_reg.jit_up)
          begin
            s_next.jit_pos = s_reg.jit_pos + 8'h01;
            if (s_reg.jit_pos == 8'(2 * JIT_DEV_CYC - 1))
              s_next.jit_up = 1'b0;
          end
          else
          begin
            s_next.jit_pos = s_reg.jit_pos - 8'h01;
            if (s_reg.jit_pos == 8'h01)
              s_next.jit_up = 1'b1;
          end
        end
        else
          s_next.jit_tmr = s_reg.jit_tmr + 12'h001;
      end

      // Pulse latch
      if (!sw_en)
        s_next.latch = 1'b0;
      else if (s_reg.latch)
      begin
        if (terminate)
          s_next.latch = 1'b0;
      end
      else if (s_reg.osc_cnt == 12'h000 && ss_lim != 12'h000)
        s_next.latch = 1'b1;

      // Edge blanking
      if (!s_reg.latch && s_next.latch)
        s_next.edge_cnt = s_reg.burst ? 6'(EDGE_BURST_CYC) : 6'(EDGE_NORM_CYC);
      else if (s_reg.edge_cnt != 6'h00)
        s_next.edge_cnt = s_reg.edge_cnt - 6'h01;

      // Burst entry blanking; exit policy belongs to the burst controller
      if (s_reg.burst)
      begin
        if (burst_out_s)
          s_next.burst = 1'b0;
        s_next.burst_tmr = 24'h000000;
      end
      else if (!burst_in_s)
        s_next.burst_tmr = 24'h000000;
      else if (s_reg.burst_tmr == BLANK_CYCLES - 24'h000001)
      begin
        s_next.burst     = 1'b1;
        s_next.burst_tmr = 24'h000000;
      end
      else
        s_next.burst_tmr = s_reg.burst_tmr + 24'h000001;

      // Protection blanking
      unique case (s_reg.prot)
        PROT_IDLE:
        begin
          s_next.prot_tmr = 24'h000000;
          if (fault_s)
            s_next.prot = PROT_BLANK;
        end
        PROT_BLANK:
        begin
          if (!fault_s)
            s_next.prot = PROT_IDLE;
          else if (s_reg.prot_tmr == BLANK_CYCLES - 24'h000001)
          begin
            s_next.prot_tmr = 24'h000000;
            s_next.ext_cnt  = 9'h000;
            s_next.prot     = extend_s ? PROT_CHG : PROT_SPIKE;
          end
          else
            s_next.prot_tmr = s_reg.prot_tmr + 24'h000001;
        end
        PROT_CHG:
        begin
          if (!fault_s)
            s_next.prot = PROT_IDLE;
          else if (bb_high_s)
          begin
            s_next.ext_cnt = s_reg.ext_cnt + 9'h001;
            s_next.prot    = (s_reg.ext_cnt == 9'(EXT_COUNT - 1)) ? PROT_SPIKE
                           : PROT_DIS;
          end
        end
        PROT_DIS:
        begin
          if (!fault_s)
            s_next.prot = PROT_IDLE;
          else if (bb_low_s)
            s_next.prot = PROT_CHG;
        end
        PROT_SPIKE:
        begin
          if (!fault_s)
            s_next.prot = PROT_IDLE;
          else if (s_reg.prot_tmr == SPIKE_CYCLES - 24'h000001)
            s_next.prot = PROT_ARST;
          else
            s_next.prot_tmr = s_reg.prot_tmr + 24'h000001;
        end
        // Held until supply collapses; bias off lets VCC fall and re-arm start-up
        PROT_ARST:
          s_next.prot = PROT_ARST;
        default:
          s_next.prot = PROT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_reg <= STATE_RST;
    else
      s_reg <= s_next;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign gate_drive             = s_reg.latch;
  assign blank_charge_switch    = (s_reg.prot == PROT_CHG);
  assign blank_discharge_switch = (s_reg.prot == PROT_DIS);
  assign burst_limit_gate       = s_reg.burst;
  assign softstart_limit_level  = s_reg.ss_done ? 6'(SS_STEPS) : s_reg.ss_step;
  assign softstart_active       = s_reg.run && !s_reg.ss_done;
  assign auto_restart           = (s_reg.prot == PROT_ARST);
  assign bias_on                = s_reg.run && (s_reg.prot != PROT_ARST);

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  gate_low_uvlo_a: assert property (!vcc_ok_s |=> !gate_drive)
    else $error("gate driven with supply below turn-off");
  ss_from_zero_a: assert property ($rose(s_reg.run) |-> s_reg.ss_step == 6'h00)
    else $error("soft start did not begin at zero");
  ss_step_rate_a: assert property (
    (s_reg.run && $past(s_reg.run) && s_reg.ss_step != $past(s_reg.ss_step))
      |-> $past(s_reg.ss_tmr) == SS_STEP_CYCLES - 16'h0001)
    else $error("soft start step at wrong time");
  ss_step_max_a: assert property (s_reg.ss_step <= 6'(SS_STEPS))
    else $error("soft start step beyond last");
  max_duty_a: assert property (gate_drive |-> s_reg.osc_cnt <= duty_lim)
    else $error("on-time beyond maximum duty");
  no_jitter_ss_a: assert property (!s_reg.ss_done |-> s_reg.per_len == 12'(OSC_PER_CYC))
    else $error("period varied during soft start");
  peak_clear_a: assert property (
    (gate_drive && cs_ok && peak_s && vcc_ok_s) |=> !gate_drive)
    else $error("peak current did not end pulse");
  latch_set_a: assert property (
    (sw_en && vcc_ok_s && !s_reg.latch && s_reg.osc_cnt == 12'h000 && ss_lim != 12'h000)
      |=> gate_drive)
    else $error("oscillator pulse did not set latch");
  edge_load_a: assert property (
    $rose(gate_drive) |-> s_reg.edge_cnt == ($past(s_reg.burst) ? 6'(EDGE_BURST_CYC)
                                                                : 6'(EDGE_NORM_CYC)))
    else $error("wrong blanking length at turn-on");
  arst_after_a: assert property (
    $rose(auto_restart) |-> $past(s_reg.prot) == PROT_SPIKE
                          && $past(s_reg.prot_tmr) == SPIKE_CYCLES - 24'h000001)
    else $error("auto-restart without spike blanking");
  ext_count_a: assert property (
    ($past(s_reg.prot) == PROT_CHG && s_reg.prot == PROT_SPIKE)
      |-> s_reg.ext_cnt == 9'(EXT_COUNT))
    else $error("extension ended at wrong count");
  arst_gate_off_a: assert property (auto_restart |=> !gate_drive)
    else $error("gate on during auto-restart");

  ss_done_c: cover property ($rose(s_reg.ss_done));
  burst_c: cover property ($rose(s_reg.burst));
  ext_spike_c: cover property ($past(s_reg.prot) == PROT_CHG && s_reg.prot == PROT_SPIKE);
  arst_c: cover property ($rose(auto_restart));

endmodule // pwm_softstart_blanking_control

// ---- bench/sense_model.sv ----
`timescale 1ns/10ps

// ************************************************************
// Current sense and blanking pin model
// ************************************************************
module sense_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        gate_drive,
  input  wire logic        blank_charge_switch,
  input  wire logic        blank_discharge_switch,
  input  wire logic [15:0] peak_delay,
  input  wire logic [15:0] fb_delay,
  input  wire logic [15:0] burst_delay,
  output logic             peak_limit_comparator,
  output logic             feedback_cmp,
  output logic             burst_limit_comparator,
  output logic             blank_pin_high_comparator,
  output logic             blank_pin_low_comparator
);
  int on_cyc;
  int pin_lvl;

  // Ramp restarts each turn-on; zero delay means never reached
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      on_cyc  <= 0;
      pin_lvl <= 0;
    end
    else
    begin
      on_cyc <= gate_drive ? on_cyc + 1 : 0;
      if (blank_charge_switch && pin_lvl < 9)
        pin_lvl <= pin_lvl + 1;
      else if (blank_discharge_switch && pin_lvl > 0)
        pin_lvl <= pin_lvl - 1;
    end
  end

  assign peak_limit_comparator     = gate_drive && peak_delay != 0 && on_cyc >= peak_delay;
  assign feedback_cmp              = gate_drive && fb_delay != 0 && on_cyc >= fb_delay;
  assign burst_limit_comparator    = gate_drive && burst_delay != 0 && on_cyc >= burst_delay;
  // Capacitor swings 0 to 9 and the thresholds 8 and 1 never overlap, so both levels never show at once
  assign blank_pin_high_comparator = pin_lvl >= 8;
  assign blank_pin_low_comparator  = pin_lvl <= 1;
endmodule // sense_model

// ---- bench/pwm_softstart_blanking_control_bench.sv ----
`timescale 1ns/10ps

module pwm_softstart_blanking_control_bench;
  // Shortened counts keep the run small
  localparam int STEP = 20;
  localparam int SS_TIME = 6000;
  localparam int BLANK = 100;
  localparam int SPIKE = 100;

  logic clk, rstn, vcc_on_cmp, vcc_above_off_cmp, overload_fault;
  logic burst_entry_cond, burst_exit_cond, extend_mode_sel;
  logic feedback_cmp, peak_limit_comparator, burst_limit_comparator;
  logic blank_pin_high_comparator, blank_pin_low_comparator;
  logic gate_drive, blank_charge_switch, blank_discharge_switch, burst_limit_gate;
  logic softstart_active, auto_restart, bias_on;
  logic [5:0] softstart_limit_level;
  logic [15:0] peak_delay, fb_delay, burst_delay;
  int fail_count, compares;

  pwm_softstart_blanking_control #(
    .SS_STEP_CYCLES(16'h0014),
    .SS_TIME_CYCLES(24'h001770),
    .BLANK_CYCLES  (24'h000064),
    .SPIKE_CYCLES  (24'h000064)
  ) u_pwm_softstart_blanking_control (.*);

  sense_model u_sense_model (.*);

  always #2.5 clk = ~clk;

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return gate_drive;
      1: return bias_on;
      2: return auto_restart;
      3: return burst_limit_gate;
      4: return softstart_active;
      default: return blank_charge_switch;
    endcase
  endfunction

  task automatic wait_lvl(input int sel, input logic v, input int lim, output int n);
    n = 0;
    while (pick(sel) !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic pulse(output int hi, output int per);
    int n;
    wait_lvl(0, 1'b0, 3000, n);
    wait_lvl(0, 1'b1, 3000, n);
    hi = 0;
    while (gate_drive === 1'b1 && hi < 3000)
    begin
      @(negedge clk);
      hi++;
    end
    per = hi;
    while (gate_drive !== 1'b1 && per < 5000)
    begin
      @(negedge clk);
      per++;
    end
  endtask

  task automatic cycle_supply();
    int n;
    vcc_on_cmp = 0;
    vcc_above_off_cmp = 0;
    repeat (5) @(negedge clk);
    check("gate off", gate_drive, 0);
    check("level cleared", softstart_limit_level, 0);
    check("restart cleared", auto_restart, 0);
    vcc_on_cmp = 1;
    vcc_above_off_cmp = 1;
    wait_lvl(1, 1'b1, 10, n);
    check("start latency", n >= 2 && n <= 4, 1);
    check("soft start rerun", softstart_active, 1);
    check("rerun from zero", softstart_limit_level, 0);
  endtask

  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_startup();
    int n, hi, per;
    time t0;
    check("gate in reset", gate_drive, 0);
    check("bias in reset", bias_on, 0);
    t0 = $time;
    vcc_on_cmp = 1;
    vcc_above_off_cmp = 1;
    wait_lvl(1, 1'b1, 10, n);
    check("start latency", n >= 2 && n <= 4, 1);
    check("first step", softstart_limit_level, 0);
    n = 0;
    while (softstart_limit_level !== 6'h01 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (softstart_limit_level !== 6'h02 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    check("step spacing", n, STEP);
    n = 0;
    while (softstart_limit_level !== 6'h20 && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    check("steps to full", n, 30 * STEP);
    pulse(hi, per);
    check("fixed period", per, 2000);
    check("full step duty", hi, 1500);
    wait_lvl(4, 1'b0, SS_TIME, n);
    n = ($time - t0) / 5;
    check("soft start length", n >= SS_TIME && n <= SS_TIME + 5, 1);
    check("limit removed", softstart_limit_level, 32);
    $display("test startup done");
  endtask

  task automatic t_jitter();
    int hi, per, moved;
    moved = 0;
    repeat (6)
    begin
      pulse(hi, per);
      check("period in sweep", per >= 1920 && per <= 2080, 1);
      check("max duty", hi <= per * 3 / 4 + 1 && hi + 2 >= per * 3 / 4, 1);
      if (per != 2000)
        moved++;
    end
    check("jitter seen", moved > 0, 1);
    $display("test jitter done");
  endtask

  task automatic t_limits();
    int hi, per;
    peak_delay = 16'h0014;
    pulse(hi, per);
    check("spike blanked", hi >= 44 && hi <= 50, 1);
    peak_delay = 16'h0064;
    pulse(hi, per);
    check("peak cut", hi >= 100 && hi <= 105, 1);
    peak_delay = 16'h0000;
    fb_delay = 16'h012C;
    pulse(hi, per);
    check("feedback cut", hi >= 300 && hi <= 305, 1);
    fb_delay = 16'h0000;
    burst_delay = 16'h003C;
    pulse(hi, per);
    check("burst limit idle", hi > 1400, 1);
    $display("test limits done");
  endtask

  task automatic t_burst();
    int n, hi, per;
    burst_entry_cond = 1;
    repeat (50) @(negedge clk);
    burst_entry_cond = 0;
    repeat (5) @(negedge clk);
    check("short dip ignored", burst_limit_gate, 0);
    burst_entry_cond = 1;
    wait_lvl(3, 1'b1, 200, n);
    check("burst entry time", n >= BLANK && n <= BLANK + 6, 1);
    pulse(hi, per);
    check("burst cut", hi >= 60 && hi <= 65, 1);
    burst_delay = 16'h0014;
    pulse(hi, per);
    check("burst blanking", hi >= 36 && hi <= 42, 1);
    burst_entry_cond = 0;
    burst_exit_cond = 1;
    wait_lvl(3, 1'b0, 10, n);
    check("burst exit", n <= 5, 1);
    burst_exit_cond = 0;
    burst_delay = 16'h0000;
    $display("test burst done");
  endtask

  task automatic t_basic();
    int n;
    overload_fault = 1;
    repeat (50) @(negedge clk);
    overload_fault = 0;
    wait_lvl(2, 1'b1, 300, n);
    check("brief fault ignored", n, 300);
    overload_fault = 1;
    wait_lvl(2, 1'b1, 400, n);
    check("restart time", n >= BLANK + SPIKE && n <= BLANK + SPIKE + 8, 1);
    n = 0;
    repeat (3000)
    begin
      @(negedge clk);
      if (gate_drive !== 1'b0)
        n++;
    end
    check("gate held off", n, 0);
    overload_fault = 0;
    cycle_supply();
    $display("test basic protection done");
  endtask

  task automatic t_extend();
    int n, highs, both, last;
    logic prev;
    extend_mode_sel = 1;
    overload_fault = 1;
    wait_lvl(5, 1'b1, 200, n);
    check("charge after blank", n >= BLANK && n <= BLANK + 6, 1);
    highs = 0;
    both = 0;
    last = 0;
    prev = 1;
    n = 0;
    while (auto_restart !== 1'b1 && n < 40000)
    begin
      @(negedge clk);
      n++;
      if (blank_pin_high_comparator && !prev)
      begin
        highs++;
        last = n;
      end
      prev = blank_pin_high_comparator;
      if (blank_charge_switch && blank_discharge_switch)
        both++;
    end
    check("charge cycles", highs, 256);
    check("switch overlap", both, 0);
    check("spike wait", n - last >= SPIKE && n - last <= SPIKE + 8, 1);
    overload_fault = 0;
    extend_mode_sel = 0;
    cycle_supply();
    $display("test extended protection done");
  endtask

  initial
  begin
    {clk, rstn, vcc_on_cmp, vcc_above_off_cmp, overload_fault} = '0;
    {burst_entry_cond, burst_exit_cond, extend_mode_sel} = '0;
    {peak_delay, fb_delay, burst_delay} = '0;
    fail_count = 0;
    compares = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rstn = 1;
    t_startup();
    t_jitter();
    t_limits();
    t_burst();
    t_basic();
    t_extend();
    wrap_up();
  end

  // Hang guard, well past the expected run
  initial
  begin
    repeat (100000) @(posedge clk);
    fail_count++;
    $display("[FAIL] watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule // pwm_softstart_blanking_control_bench
